// ===== src/anl_regs_pkg.sv
// Offsets, layouts and reset values of the negotiation and training registers.
package anl_regs_pkg;

  localparam int ADDR_W = 16;

  localparam logic [15:0] OFS_NEG_CTL_ONE = 16'h00e0;
  localparam logic [15:0] OFS_NEG_CTL_TWO = 16'h00e4;
  localparam logic [15:0] OFS_NEG_ABILITY = 16'h00f8;
  localparam logic [15:0] OFS_TRAIN_CTL = 16'h0100;
  localparam logic [15:0] OFS_RX_TRAINED = 16'h0104;
  localparam logic [15:0] OFS_PRESET = 16'h0108;
  localparam logic [15:0] OFS_INITIALIZE = 16'h010c;
  localparam logic [15:0] OFS_SEED_L01 = 16'h0110;
  localparam logic [15:0] OFS_SEED_L23 = 16'h0114;
  localparam logic [15:0] OFS_COEFF_L01 = 16'h0130;
  localparam logic [15:0] OFS_COEFF_L23 = 16'h0134;
  localparam logic [15:0] OFS_SCRATCH = 16'h0138;
  localparam logic [15:0] OFS_SPEED_SWITCH = 16'h013c;
  localparam logic [15:0] OFS_TX_STATUS = 16'h0400;
  localparam logic [15:0] OFS_RX_STATUS = 16'h0404;
  localparam logic [15:0] OFS_FIFO_STATUS = 16'h0408;

  // Field positions.
  localparam int NEG1_MSB = 12;
  localparam int NEG2_PAUSE = 0;
  localparam int NEG2_ADV_MSB = 1;
  localparam int NEG2_FEC_LSB = 16;
  localparam int NEG2_FEC_MSB = 21;
  localparam int ABILITY_MSB = 14;
  localparam int TRAIN_MSB = 1;
  localparam int LANE_MSB = 3;
  localparam int SEED_MSB = 10;
  localparam int HI_LANE_LSB = 16;
  localparam int COEFF_MSB = 11;
  localparam int SWITCH_BIT = 0;
  localparam int TX_FAULT_BIT = 0;
  localparam int RX_STAT_MSB = 11;
  localparam int FIFO_TX_ERR = 0;
  localparam int FIFO_UNDERFLOW = 1;
  localparam int FIFO_OVERFLOW = 2;
  localparam int FIFO_TS_RD_ERR = 4;
  localparam int FIFO_TS_WR_ERR = 5;
  localparam int FIFO_RX_ERR = 16;

  // Reset values; only the bypass bit and the two sticky-low bits start high.
  localparam logic [12:0] NEG1_RESET = 13'h0002;
  localparam logic [11:0] RX_STAT_RESET = 12'h003;
  localparam logic [11:0] RX_STICKY_LOW = 12'h003;
  localparam logic [11:0] RX_MAC_ONLY = 12'hfa0;

  typedef struct packed {
    logic faultAdvertise;
    logic restart;
    logic prbsSelect;
    logic [7:0] randomSeed;
    logic bypass;
    logic enable;
  } anl_neg_one_t;

  typedef struct packed {
    anl_neg_one_t negOne;
    logic advertiseAsymDirection;
    logic advertiseFlowPause;
    logic [5:0] fecRequest;
    logic [14:0] advertiseTech;
    logic trainingRestart;
    logic trainingEnable;
    logic [3:0] laneReceiverTrained;
    logic [3:0] lanePresetSend;
    logic [3:0] laneInitializeSend;
    logic [3:0][10:0] laneTrainingSeed;
    logic [3:0][11:0] laneCoeff;
    logic [31:0] scratchWord;
    logic speedSwitch;
  } anl_ctl_t;

  typedef struct packed {
    logic txLocalFault;
    logic [11:0] rxStatus;
    logic txFifoError;
    logic txUnderflow;
    logic txOverflow;
    logic tsFifoReadError;
    logic tsFifoWriteError;
    logic rxFifoError;
  } anl_stat_t;

  typedef struct packed {
    anl_ctl_t ctl;
    anl_stat_t sticky;
    logic [31:0] rdData;
    logic rdValid;
  } anl_state_t;

endpackage : anl_regs_pkg

// ===== src/anl_config_status_regs.sv
// Register bank for negotiation, training, speed switch and first status words.
// How it works
// - Sticky status bits hold their event until read.
// - Runtime switch mode: bit0 write requests speed change.
// - Speed-switch request clears itself after each write.
// - Switch request drives the transceiver reconfiguration module.
// - Negotiation bypass resets to one.
// - Control one: enable, bypass, seed, prbs, restart, fault.
// - Control two: pause, asym, FEC bits 16-21.
// - Ability bits 0-14, read-write, reset zero.
// - Training enable bit0, restart bit1, reset zero.
// - Trained, preset, initialize: 4-bit lane fields.
// - Two 11-bit lane seeds per register.
// - Twelve-bit coefficient fields, two lanes per register.
// - Scratch word reads back last write.
// - Transmit local fault is sticky-high, reset zero.
// - Link status and aligned reset one, sticky-low.
// - Receive bits 2-11 sticky-high, reset zero.
// - Some fault bits exist only with MAC.
// - Underflow/overflow only in 256-bit 40G variant.
// - FIFO error bits only in PCS-only variant.
// - Timestamp FIFO errors are sticky-high, reset zero.
`timescale 1ns/1ps
`default_nettype none

module anl_config_status_regs #(
  parameter bit HAS_MAC = 1'b1,
  parameter bit WIDE_40G = 1'b0,
  parameter bit RUNTIME_SWITCH = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [anl_regs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  // Live status from the core.
  input wire anl_regs_pkg::anl_stat_t liveStatus,
  // Controls to the core.
  output anl_regs_pkg::anl_ctl_t coreCtl
);

  localparam bit HAS_PCS_ONLY = !HAS_MAC;
  localparam bit HAS_WIDE = HAS_MAC && WIDE_40G;

  anl_regs_pkg::anl_state_t state_q;
  anl_regs_pkg::anl_state_t state_d;
  anl_regs_pkg::anl_stat_t live;
  logic [31:0] wd;
  logic [1:0] lanePair;

  assign regRdData = state_q.rdData;
  assign regRdValid = state_q.rdValid;
  assign coreCtl = state_q.ctl;

  // Bits absent from a variant read zero and never latch.
  always_comb begin
    live = liveStatus;
    live.rxStatus = liveStatus.rxStatus &
      (HAS_MAC ? 12'hfff : ~anl_regs_pkg::RX_MAC_ONLY);
    live.tsFifoReadError = liveStatus.tsFifoReadError & HAS_MAC;
    live.tsFifoWriteError = liveStatus.tsFifoWriteError & HAS_MAC;
    live.txUnderflow = liveStatus.txUnderflow & HAS_WIDE;
    live.txOverflow = liveStatus.txOverflow & HAS_WIDE;
    live.txFifoError = liveStatus.txFifoError & HAS_PCS_ONLY;
    live.rxFifoError = liveStatus.rxFifoError & HAS_PCS_ONLY;
  end

  always_comb begin
    state_d = state_q;
    wd = regWrData;
    lanePair = 2'h0;
    state_d.rdValid = regRead;
    state_d.ctl.speedSwitch = 1'b0;

    if (regWrite) begin
      case (regAddr)
        anl_regs_pkg::OFS_NEG_CTL_ONE: begin
          state_d.ctl.negOne = wd[anl_regs_pkg::NEG1_MSB:0];
        end
        anl_regs_pkg::OFS_NEG_CTL_TWO: begin
          state_d.ctl.advertiseFlowPause =
            wd[anl_regs_pkg::NEG2_PAUSE];
          state_d.ctl.advertiseAsymDirection = wd[anl_regs_pkg::NEG2_ADV_MSB];
          state_d.ctl.fecRequest =
            wd[anl_regs_pkg::NEG2_FEC_MSB:anl_regs_pkg::NEG2_FEC_LSB];
        end
        anl_regs_pkg::OFS_NEG_ABILITY: begin
          state_d.ctl.advertiseTech = wd[anl_regs_pkg::ABILITY_MSB:0];
        end
        anl_regs_pkg::OFS_TRAIN_CTL: begin
          {state_d.ctl.trainingRestart, state_d.ctl.trainingEnable} =
            wd[anl_regs_pkg::TRAIN_MSB:0];
        end
        anl_regs_pkg::OFS_RX_TRAINED: begin
          state_d.ctl.laneReceiverTrained = wd[anl_regs_pkg::LANE_MSB:0];
        end
        anl_regs_pkg::OFS_PRESET: begin
          state_d.ctl.lanePresetSend = wd[anl_regs_pkg::LANE_MSB:0];
        end
        anl_regs_pkg::OFS_INITIALIZE: begin
          state_d.ctl.laneInitializeSend = wd[anl_regs_pkg::LANE_MSB:0];
        end
        anl_regs_pkg::OFS_SEED_L01, anl_regs_pkg::OFS_SEED_L23: begin
          lanePair = (regAddr == anl_regs_pkg::OFS_SEED_L23) ? 2'h2 : 2'h0;
          state_d.ctl.laneTrainingSeed[lanePair] =
            wd[anl_regs_pkg::SEED_MSB:0];
          state_d.ctl.laneTrainingSeed[lanePair + 2'h1] =
            wd[anl_regs_pkg::HI_LANE_LSB+anl_regs_pkg::SEED_MSB:
               anl_regs_pkg::HI_LANE_LSB];
        end
        anl_regs_pkg::OFS_COEFF_L01, anl_regs_pkg::OFS_COEFF_L23: begin
          lanePair = (regAddr == anl_regs_pkg::OFS_COEFF_L23) ? 2'h2 : 2'h0;
          state_d.ctl.laneCoeff[lanePair] = wd[anl_regs_pkg::COEFF_MSB:0];
          state_d.ctl.laneCoeff[lanePair + 2'h1] =
            wd[anl_regs_pkg::HI_LANE_LSB+anl_regs_pkg::COEFF_MSB:
               anl_regs_pkg::HI_LANE_LSB];
        end
        anl_regs_pkg::OFS_SCRATCH: begin
          state_d.ctl.scratchWord = wd;
        end
        anl_regs_pkg::OFS_SPEED_SWITCH: begin
          // A single cycle pulse per write; outside runtime switch mode the
          // write is accepted but has no effect.
          state_d.ctl.speedSwitch =
            wd[anl_regs_pkg::SWITCH_BIT] & RUNTIME_SWITCH;
        end
        default: begin
          state_d.ctl = state_d.ctl;
        end
      endcase
    end

    // Sticky bits: a read reloads the live value, so an event in the read
    // cycle re-latches at once and is never lost.
    state_d.sticky.txLocalFault = live.txLocalFault |
      (state_q.sticky.txLocalFault &
       ~(regRead && regAddr == anl_regs_pkg::OFS_TX_STATUS));
    if (regRead && regAddr == anl_regs_pkg::OFS_RX_STATUS) begin
      state_d.sticky.rxStatus = live.rxStatus;
    end else begin
      state_d.sticky.rxStatus =
        (state_q.sticky.rxStatus & live.rxStatus &
         anl_regs_pkg::RX_STICKY_LOW) |
        ((state_q.sticky.rxStatus | live.rxStatus) &
         ~anl_regs_pkg::RX_STICKY_LOW);
    end
    if (regRead && regAddr == anl_regs_pkg::OFS_FIFO_STATUS) begin
      state_d.sticky.txFifoError = live.txFifoError;
      state_d.sticky.txUnderflow = live.txUnderflow;
      state_d.sticky.txOverflow = live.txOverflow;
      state_d.sticky.tsFifoReadError = live.tsFifoReadError;
      state_d.sticky.tsFifoWriteError = live.tsFifoWriteError;
      state_d.sticky.rxFifoError = live.rxFifoError;
    end else begin
      state_d.sticky.txFifoError =
        state_q.sticky.txFifoError | live.txFifoError;
      state_d.sticky.txUnderflow =
        state_q.sticky.txUnderflow | live.txUnderflow;
      state_d.sticky.txOverflow =
        state_q.sticky.txOverflow | live.txOverflow;
      state_d.sticky.tsFifoReadError =
        state_q.sticky.tsFifoReadError | live.tsFifoReadError;
      state_d.sticky.tsFifoWriteError =
        state_q.sticky.tsFifoWriteError | live.tsFifoWriteError;
      state_d.sticky.rxFifoError =
        state_q.sticky.rxFifoError | live.rxFifoError;
    end

    // Read data shows the held value, before the reload above takes effect.
    state_d.rdData = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        anl_regs_pkg::OFS_NEG_CTL_ONE: begin
          state_d.rdData[anl_regs_pkg::NEG1_MSB:0] = state_q.ctl.negOne;
        end
        anl_regs_pkg::OFS_NEG_CTL_TWO: begin
          state_d.rdData[anl_regs_pkg::NEG2_ADV_MSB:0] =
            {state_q.ctl.advertiseAsymDirection, state_q.ctl.advertiseFlowPause};
          state_d.rdData[anl_regs_pkg::NEG2_FEC_MSB:anl_regs_pkg::NEG2_FEC_LSB] =
            state_q.ctl.fecRequest;
        end
        anl_regs_pkg::OFS_NEG_ABILITY: begin
          state_d.rdData[anl_regs_pkg::ABILITY_MSB:0] = state_q.ctl.advertiseTech;
        end
        anl_regs_pkg::OFS_TRAIN_CTL: begin
          state_d.rdData[anl_regs_pkg::TRAIN_MSB:0] =
            {state_q.ctl.trainingRestart, state_q.ctl.trainingEnable};
        end
        anl_regs_pkg::OFS_RX_TRAINED: begin
          state_d.rdData[anl_regs_pkg::LANE_MSB:0] =
            state_q.ctl.laneReceiverTrained;
        end
        anl_regs_pkg::OFS_PRESET: begin
          state_d.rdData[anl_regs_pkg::LANE_MSB:0] = state_q.ctl.lanePresetSend;
        end
        anl_regs_pkg::OFS_INITIALIZE: begin
          state_d.rdData[anl_regs_pkg::LANE_MSB:0] =
            state_q.ctl.laneInitializeSend;
        end
        anl_regs_pkg::OFS_SEED_L01, anl_regs_pkg::OFS_SEED_L23: begin
          lanePair = (regAddr == anl_regs_pkg::OFS_SEED_L23) ? 2'h2 : 2'h0;
          state_d.rdData[anl_regs_pkg::SEED_MSB:0] =
            state_q.ctl.laneTrainingSeed[lanePair];
          state_d.rdData[anl_regs_pkg::HI_LANE_LSB+anl_regs_pkg::SEED_MSB:
                         anl_regs_pkg::HI_LANE_LSB] =
            state_q.ctl.laneTrainingSeed[lanePair + 2'h1];
        end
        anl_regs_pkg::OFS_COEFF_L01, anl_regs_pkg::OFS_COEFF_L23: begin
          lanePair = (regAddr == anl_regs_pkg::OFS_COEFF_L23) ? 2'h2 : 2'h0;
          state_d.rdData[anl_regs_pkg::COEFF_MSB:0] =
            state_q.ctl.laneCoeff[lanePair];
          state_d.rdData[anl_regs_pkg::HI_LANE_LSB+anl_regs_pkg::COEFF_MSB:
                         anl_regs_pkg::HI_LANE_LSB] =
            state_q.ctl.laneCoeff[lanePair + 2'h1];
        end
        anl_regs_pkg::OFS_SCRATCH: begin
          state_d.rdData = state_q.ctl.scratchWord;
        end
        anl_regs_pkg::OFS_SPEED_SWITCH: begin
          state_d.rdData = 32'h0000_0000;
        end
        anl_regs_pkg::OFS_TX_STATUS: begin
          state_d.rdData[anl_regs_pkg::TX_FAULT_BIT] =
            state_q.sticky.txLocalFault;
        end
        anl_regs_pkg::OFS_RX_STATUS: begin
          state_d.rdData[anl_regs_pkg::RX_STAT_MSB:0] = state_q.sticky.rxStatus;
        end
        anl_regs_pkg::OFS_FIFO_STATUS: begin
          state_d.rdData[anl_regs_pkg::FIFO_TX_ERR] = state_q.sticky.txFifoError;
          state_d.rdData[anl_regs_pkg::FIFO_UNDERFLOW] =
            state_q.sticky.txUnderflow;
          state_d.rdData[anl_regs_pkg::FIFO_OVERFLOW] = state_q.sticky.txOverflow;
          state_d.rdData[anl_regs_pkg::FIFO_TS_RD_ERR] =
            state_q.sticky.tsFifoReadError;
          state_d.rdData[anl_regs_pkg::FIFO_TS_WR_ERR] =
            state_q.sticky.tsFifoWriteError;
          state_d.rdData[anl_regs_pkg::FIFO_RX_ERR] = state_q.sticky.rxFifoError;
        end
        default: begin
          state_d.rdData = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
      state_q.ctl.negOne <= anl_regs_pkg::NEG1_RESET;
      state_q.sticky.rxStatus <= anl_regs_pkg::RX_STAT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

endmodule : anl_config_status_regs

`default_nettype wire

// ===== sim/anl_regs_monitor.sv
// Checker for the negotiation and training register bank ports.
`timescale 1ns/1ps
`default_nettype none

module anl_regs_monitor #(
  parameter bit SWITCH_MODE = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [anl_regs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid,
  // Core side.
  input wire anl_regs_pkg::anl_stat_t liveStatus,
  input wire anl_regs_pkg::anl_ctl_t coreCtl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic wrSw;
  logic wrScr;
  logic wrN1;
  logic rdTx;
  logic rdRx;
  assign wrSw = regWrite && regAddr == anl_regs_pkg::OFS_SPEED_SWITCH;
  assign wrScr = regWrite && regAddr == anl_regs_pkg::OFS_SCRATCH;
  assign wrN1 = regWrite && regAddr == anl_regs_pkg::OFS_NEG_CTL_ONE;
  assign rdTx = regRead && regAddr == anl_regs_pkg::OFS_TX_STATUS;
  assign rdRx = regRead && regAddr == anl_regs_pkg::OFS_RX_STATUS;

  sequence switch_req_s;
    (SWITCH_MODE && wrSw && regWrData[0]) ##1 !(wrSw && regWrData[0]);
  endsequence
  sequence switch_pulse_s;
    coreCtl.speedSwitch ##1 !coreCtl.speedSwitch;
  endsequence

  switch_pulse_a: assert property (
    switch_req_s |-> switch_pulse_s)
    else $error("speed switch pulse wrong");
  switch_cause_a: assert property (
    coreCtl.speedSwitch |-> $past(wrSw && regWrData[0]))
    else $error("speed switch without write");
  switch_off_a: assert property (
    !SWITCH_MODE |-> !coreCtl.speedSwitch)
    else $error("speed switch outside runtime mode");
  scratch_write_a: assert property (
    wrScr |=> coreCtl.scratchWord == $past(regWrData))
    else $error("scratch word not written");
  scratch_hold_a: assert property (
    !wrScr |=> $stable(coreCtl.scratchWord))
    else $error("scratch word changed unasked");
  neg_one_write_a: assert property (
    wrN1 |=> coreCtl.negOne == $past(regWrData[12:0]))
    else $error("negotiation control one layout wrong");
  bypass_reset_a: assert property (
    $rose(nrst) |-> coreCtl.negOne.bypass && !coreCtl.negOne.enable)
    else $error("bypass not set out of reset");
  tx_latch_a: assert property (
    rdTx && $past(liveStatus.txLocalFault) && $past(nrst)
    |=> regRdValid && regRdData[0])
    else $error("transmit fault not held");
  rx_latch_a: assert property (
    rdRx && $past(!liveStatus.rxStatus[0]) && $past(nrst)
    |=> regRdValid && !regRdData[0])
    else $error("link loss not held");
endmodule : anl_regs_monitor

bind anl_config_status_regs anl_regs_monitor #(.SWITCH_MODE(RUNTIME_SWITCH))
  u_mon (
  .clk(clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .regRdValid(regRdValid), .liveStatus(liveStatus), .coreCtl(coreCtl)
);

`default_nettype wire

// ===== sim/anl_core_model.sv
// Core-side model: live status source and speed-change request counter.
`timescale 1ns/1ps
`default_nettype none

module anl_core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Status levels asked for by the bench.
  input wire anl_regs_pkg::anl_stat_t wantStatus,
  // Bank side.
  input wire anl_regs_pkg::anl_ctl_t coreCtl,
  output anl_regs_pkg::anl_stat_t liveStatus,
  output int switchCount
);
  // Levels pass straight through so the bench controls event timing exactly.
  assign liveStatus = wantStatus;

  // Counts request cycles as the reconfiguration logic would see them.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      switchCount <= 0;
    end else if (coreCtl.speedSwitch) begin
      switchCount <= switchCount + 1;
    end
  end
endmodule : anl_core_model

`default_nettype wire

// ===== sim/anl_config_status_regs_tb_top.sv
// Self-checking bench for the negotiation and training register bank.
`timescale 1ns/1ps
`default_nettype none

module anl_config_status_regs_tb_top;
  logic clk;
  logic nrst;
  logic regWrite;
  logic regRead;
  logic [anl_regs_pkg::ADDR_W-1:0] regAddr;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic regRdValid;
  anl_regs_pkg::anl_stat_t wantStatus;
  anl_regs_pkg::anl_stat_t liveStatus;
  anl_regs_pkg::anl_ctl_t coreCtl;
  int switchCount;
  logic [31:0] pcsRdData;
  logic [31:0] wideRdData;
  int failCount = 0;
  int checksDone = 0;
  localparam logic [15:0] OFS [13] = '{anl_regs_pkg::OFS_NEG_CTL_ONE,
    anl_regs_pkg::OFS_NEG_CTL_TWO, anl_regs_pkg::OFS_NEG_ABILITY,
    anl_regs_pkg::OFS_TRAIN_CTL, anl_regs_pkg::OFS_RX_TRAINED,
    anl_regs_pkg::OFS_PRESET, anl_regs_pkg::OFS_INITIALIZE,
    anl_regs_pkg::OFS_SEED_L01, anl_regs_pkg::OFS_SEED_L23,
    anl_regs_pkg::OFS_COEFF_L01, anl_regs_pkg::OFS_COEFF_L23,
    anl_regs_pkg::OFS_SCRATCH, anl_regs_pkg::OFS_SPEED_SWITCH};
  localparam logic [31:0] MASK [13] = '{32'h1fff, 32'h3f0003, 32'h7fff,
    32'h3, 32'hf, 32'hf, 32'hf, 32'h07ff07ff, 32'h07ff07ff, 32'h0fff0fff,
    32'h0fff0fff, 32'hffffffff, 32'h0};

  anl_config_status_regs #(.HAS_MAC(1'b1), .WIDE_40G(1'b0),
    .RUNTIME_SWITCH(1'b1)) dut (.clk(clk), .nrst(nrst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .liveStatus(liveStatus), .coreCtl(coreCtl));
  anl_core_model model (.clk(clk), .nrst(nrst), .wantStatus(wantStatus),
    .coreCtl(coreCtl), .liveStatus(liveStatus), .switchCount(switchCount));
  // Two more variants share the bus so variant-only bits are seen to latch.
  anl_config_status_regs #(.HAS_MAC(1'b0), .WIDE_40G(1'b0),
    .RUNTIME_SWITCH(1'b0)) dutPcs (.clk(clk), .nrst(nrst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(pcsRdData), .regRdValid(),
    .liveStatus(liveStatus), .coreCtl());
  anl_config_status_regs #(.HAS_MAC(1'b1), .WIDE_40G(1'b1),
    .RUNTIME_SWITCH(1'b1)) dutWide (.clk(clk), .nrst(nrst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(wideRdData), .regRdValid(),
    .liveStatus(liveStatus), .coreCtl());

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [15:0] a,
                    input logic [31:0] e);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    chk({n, " valid"}, 32'h1, 32'(regRdValid));
    chk(n, e, regRdData);
  endtask : rd

  task automatic t_reset;
    for (int i = 0; i < 13; i++) begin
      rd($sformatf("reset %h", OFS[i]), OFS[i], (i == 0) ? 32'h2 : 32'h0);
    end
    rd("tx reset", anl_regs_pkg::OFS_TX_STATUS, 32'h0);
    rd("rx reset", anl_regs_pkg::OFS_RX_STATUS, 32'h3);
    rd("fifo reset", anl_regs_pkg::OFS_FIFO_STATUS, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_rw;
    for (int i = 0; i < 13; i++) begin
      wr(OFS[i], 32'hffffffff);
      rd($sformatf("ones %h", OFS[i]), OFS[i], MASK[i]);
      wr(OFS[i], 32'h0);
      rd($sformatf("zero %h", OFS[i]), OFS[i], 32'h0);
    end
    wr(anl_regs_pkg::OFS_RX_STATUS, 32'hffffffff);
    rd("rx after write", anl_regs_pkg::OFS_RX_STATUS, 32'h3);
    wr(16'h0200, 32'hffffffff);
    rd("unmapped", 16'h0200, 32'h0);
    $display("read write test done");
  endtask : t_rw

  task automatic t_fields;
    wr(anl_regs_pkg::OFS_NEG_CTL_ONE, 32'h0295);
    chk("enable", 32'h1, 32'(coreCtl.negOne.enable));
    chk("bypass", 32'h0, 32'(coreCtl.negOne.bypass));
    chk("seed", 32'ha5, 32'(coreCtl.negOne.randomSeed));
    wr(anl_regs_pkg::OFS_NEG_CTL_TWO, 32'h00210002);
    chk("fec", 32'h21, 32'(coreCtl.fecRequest));
    chk("asym", 32'h1, 32'(coreCtl.advertiseAsymDirection));
    chk("pause", 32'h0, 32'(coreCtl.advertiseFlowPause));
    wr(anl_regs_pkg::OFS_SEED_L01, 32'h01230456);
    chk("seed lane0", 32'h456, 32'(coreCtl.laneTrainingSeed[0]));
    chk("seed lane1", 32'h123, 32'(coreCtl.laneTrainingSeed[1]));
    wr(anl_regs_pkg::OFS_COEFF_L23, 32'h0abc0123);
    chk("coeff lane2", 32'h123, 32'(coreCtl.laneCoeff[2]));
    chk("coeff lane3", 32'habc, 32'(coreCtl.laneCoeff[3]));
    wr(anl_regs_pkg::OFS_PRESET, 32'ha);
    chk("preset", 32'ha, 32'(coreCtl.lanePresetSend));
    wr(anl_regs_pkg::OFS_SCRATCH, 32'h5a5aa5a5);
    rd("scratch", anl_regs_pkg::OFS_SCRATCH, 32'h5a5aa5a5);
    $display("field test done");
  endtask : t_fields

  task automatic t_switch;
    int c0;
    c0 = switchCount;
    wr(anl_regs_pkg::OFS_SPEED_SWITCH, 32'h1);
    @(negedge clk);
    chk("one request", 32'(c0 + 1), 32'(switchCount));
    wr(anl_regs_pkg::OFS_SPEED_SWITCH, 32'h0);
    @(negedge clk);
    chk("zero write", 32'(c0 + 1), 32'(switchCount));
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = anl_regs_pkg::OFS_SPEED_SWITCH;
    regWrData = 32'h1;
    repeat (2) @(negedge clk);
    regWrite = 1'b0;
    repeat (2) @(negedge clk);
    chk("two requests", 32'(c0 + 3), 32'(switchCount));
    rd("switch read", anl_regs_pkg::OFS_SPEED_SWITCH, 32'h0);
    $display("switch test done");
  endtask : t_switch

  task automatic t_sticky;
    @(negedge clk);
    wantStatus.txLocalFault = 1'b1;
    rd("tx held", anl_regs_pkg::OFS_TX_STATUS, 32'h1);
    wantStatus.txLocalFault = 1'b0;
    rd("tx relatch", anl_regs_pkg::OFS_TX_STATUS, 32'h1);
    rd("tx clear", anl_regs_pkg::OFS_TX_STATUS, 32'h0);
    @(negedge clk);
    wantStatus.rxStatus[0] = 1'b0;
    rd("rx low", anl_regs_pkg::OFS_RX_STATUS, 32'h2);
    wantStatus.rxStatus[0] = 1'b1;
    rd("rx low again", anl_regs_pkg::OFS_RX_STATUS, 32'h2);
    rd("rx up", anl_regs_pkg::OFS_RX_STATUS, 32'h3);
    @(negedge clk);
    wantStatus.rxStatus = 12'hfff;
    rd("rx events", anl_regs_pkg::OFS_RX_STATUS, 32'hfff);
    chk("rx events pcs", 32'h05f, pcsRdData);
    wantStatus.rxStatus = 12'h003;
    rd("rx events kept", anl_regs_pkg::OFS_RX_STATUS, 32'hfff);
    rd("rx events gone", anl_regs_pkg::OFS_RX_STATUS, 32'h3);
    // Every fifo event pulses once; only the present variant bits may stick.
    @(negedge clk);
    wantStatus[5:0] = 6'h3f;
    @(negedge clk);
    wantStatus[5:0] = 6'h00;
    rd("fifo", anl_regs_pkg::OFS_FIFO_STATUS, 32'h30);
    chk("fifo pcs", 32'h00010001, pcsRdData);
    chk("fifo wide", 32'h36, wideRdData);
    rd("fifo clear", anl_regs_pkg::OFS_FIFO_STATUS, 32'h0);
    chk("fifo pcs clear", 32'h0, pcsRdData);
    $display("sticky test done");
  endtask : t_sticky

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrapUp

  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWrData = 32'h0;
    wantStatus = '0;
    wantStatus.rxStatus = 12'h003;
    nrst = 1'b0;
    repeat (16) @(posedge clk);
    chk("bypass in reset", 32'h1, 32'(coreCtl.negOne.bypass));
    @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_rw();
    t_fields();
    t_switch();
    t_sticky();
    wrapUp();
  end

  // The sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    $display("watchdog expired");
    wrapUp();
  end
endmodule : anl_config_status_regs_tb_top

`default_nettype wire
